// file: prts_pkg.sv
package prts_pkg;
   localparam logic [5:0] TABLE_ADDR      = 6'h3e;
   localparam int         HDR_RW_POS      = 7;
   localparam int         HDR_BURST_POS   = 6;
   localparam int         STAT_RDY_POS    = 7;
   localparam logic [3:0] FIFO_COUNT_MAX  = 4'hf;
   localparam logic [7:0] TABLE_RESET     = 8'h00;
   localparam logic [7:0] STATUS_RESET    = 8'h80;
   localparam int         CLK_DIV_HALF    = 8;
   localparam logic [4:0] CMD_RD_OFF      = 5'h00;
   localparam logic [4:0] CMD_WR_OFF      = 5'h01;
   localparam logic [4:0] CMD_HDR_OFF     = 5'h02;
   localparam logic [4:0] CMD_GO_OFF      = 5'h03;
   localparam logic [4:0] CMD_STAT_OFF    = 5'h04;
   localparam logic [4:0] CMD_LEN_OFF     = 5'h05;
   localparam logic [4:0] CMD_DATA_OFF    = 5'h08;

   typedef enum logic [2:0] {
      PRTS_ST_IDLE      = 3'b000,
      PRTS_ST_RX        = 3'b001,
      PRTS_ST_TX        = 3'b010,
      PRTS_ST_FTX_READY = 3'b011,
      PRTS_ST_CAL       = 3'b100,
      PRTS_ST_SETTLE    = 3'b101,
      PRTS_ST_RX_OVF    = 3'b110,
      PRTS_ST_TX_UNF    = 3'b111
   } prts_radio_state_t;
endpackage

// file: prts_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface prts_link_if;
   logic sclk;
   logic si;
   logic so;
   logic chip_select_n;

   modport dev  (input sclk, input si, input chip_select_n, output so);
   modport host (output sclk, output si, output chip_select_n, input so);
endinterface
`default_nettype wire

// file: prts_device.sv
// Notes on behaviour
// - Header address 0x3e selects the table
// - Up to eight data bytes follow header
// - Eight entries, chosen by 3-bit selector
// - Index advances after each table byte
// - Chip select high resets index
// - Index wraps seven to zero
// - Header bit 7 chooses read or write
// - Burst bit allows many bytes per frame
// - Host raises select before reading back
// - Sleep keeps only entry zero
// - Status bit 7 high until ready
// - Host transfers only when ready
// - Status bits 6:4 show main state
// - Idle may replace settle or calibrate
// - Receive overflow shows code 110
// - Transmit underflow shows code 111
// - Low nibble: rx available or tx free
// - Count saturates at fifteen
// - Status shifts out during header
// - Bytes shift most significant first
// - Header holds rw, burst, 6-bit address
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module prts_device (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   // Link
   prts_link_if.dev        link,
   // Chip state
   input  wire logic       ready_i,
   input  wire logic [2:0] radio_state_i,
   input  wire logic [6:0] rx_avail_i,
   input  wire logic [6:0] tx_free_i,
   input  wire logic       sleep_enter_i,
   input  wire logic [2:0] power_level_selector_i,
   // Table output and serial output enable
   output logic      [7:0] pa_setting_o,
   output logic            so_oe_o
);
   logic [2:0] sclk_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] si_s_q;
   logic [7:0] tbl_q [8];
   logic [2:0] idx_q;
   logic [2:0] bit_q;
   logic [7:0] sh_in_q;
   logic [7:0] sh_out_q;
   logic       hdr_done_q;
   logic       tbl_sel_q;
   logic       rd_q;
   logic       burst_q;
   logic       dead_q;
   logic       so_q;
   logic [7:0] pa_q;

   // Link edges and byte decode
   wire        sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
   wire        sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
   wire        cs_low    = ~cs_s_q[1];
   wire [7:0]  byte_in   = {sh_in_q[6:0], si_s_q[1]};
   wire        byte_end  = sclk_rise & (bit_q == 3'd7);
   wire        hdr_end   = byte_end & ~hdr_done_q;
   wire        tbl_step  = byte_end & hdr_done_q & tbl_sel_q & ~dead_q;
   wire        tbl_wr    = tbl_step & ~rd_q;
   wire        pre_hdr   = cs_low & ~hdr_done_q & (bit_q == 3'd0);
   wire        shift_so  = sclk_fall & (bit_q != 3'd0);
   wire        load_so   = sclk_fall & (bit_q == 3'd0) & hdr_done_q;
   wire        hdr_rd    = byte_in[prts_pkg::HDR_RW_POS];
   wire        hdr_burst = byte_in[prts_pkg::HDR_BURST_POS];
   wire        hdr_tbl   = (byte_in[5:0] == prts_pkg::TABLE_ADDR);
   wire [2:0]  idx_next  = idx_q + 3'd1;

   // Saturating count and status composition
   function automatic logic [3:0] sat4(input logic [6:0] v);
      sat4 = (v > 7'(prts_pkg::FIFO_COUNT_MAX)) ? prts_pkg::FIFO_COUNT_MAX : v[3:0];
   endfunction

   function automatic logic [7:0] status_byte(input logic       rdy,
                                              input logic [2:0] st,
                                              input logic [6:0] cnt);
      status_byte = {~rdy, st, sat4(cnt)};
   endfunction

   // Header status always carries the rx count; write bytes carry the tx count
   wire [7:0]  status_rd = status_byte(ready_i, radio_state_i, rx_avail_i);
   wire [7:0]  status_wr = status_byte(ready_i, radio_state_i, tx_free_i);
   wire [7:0]  hdr_out   = hdr_rd ? tbl_q[idx_q] : status_wr;
   wire [7:0]  next_out  = rd_q ? tbl_q[idx_next] : status_wr;

   // Pin and output drive
   assign link.so      = so_q;
   assign so_oe_o      = cs_low;
   assign pa_setting_o = pa_q;

   // Two-flop synchronisers for the link pins
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_s_q <= 3'h0;
         cs_s_q   <= 2'h3;
         si_s_q   <= 2'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], link.sclk};
         cs_s_q   <= {cs_s_q[0], link.chip_select_n};
         si_s_q   <= {si_s_q[0], link.si};
      end
   end

   // Active power setting
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pa_q <= prts_pkg::TABLE_RESET;
      end else begin
         pa_q <= tbl_q[power_level_selector_i];
      end
   end

   // Table entries; a write in progress wins over a sleep clear
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_entry
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               tbl_q[g] <= prts_pkg::TABLE_RESET;
            end else if (tbl_wr && idx_q == 3'(g)) begin
               tbl_q[g] <= byte_in;
            end else if (sleep_enter_i && g != 0) begin
               tbl_q[g] <= prts_pkg::TABLE_RESET;
            end
         end
      end
   endgenerate

   // Bit counter and input shifter
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_q   <= 3'h0;
         sh_in_q <= 8'h00;
      end else if (!cs_low) begin
         bit_q   <= 3'h0;
      end else if (sclk_rise) begin
         sh_in_q <= byte_in;
         bit_q   <= bit_q + 3'd1;
      end
   end

   // Header capture
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hdr_done_q <= 1'b0;
         tbl_sel_q  <= 1'b0;
         rd_q       <= 1'b0;
         burst_q    <= 1'b0;
      end else if (!cs_low) begin
         hdr_done_q <= 1'b0;
         tbl_sel_q  <= 1'b0;
      end else if (hdr_end) begin
         hdr_done_q <= 1'b1;
         rd_q       <= hdr_rd;
         burst_q    <= hdr_burst;
         tbl_sel_q  <= hdr_tbl;
      end
   end

   // Table index
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         idx_q  <= 3'h0;
         dead_q <= 1'b0;
      end else if (!cs_low) begin
         idx_q  <= 3'h0;
         dead_q <= 1'b0;
      end else if (tbl_step) begin
         idx_q  <= idx_next;
         dead_q <= ~burst_q;
      end
   end

   // Output shifter, status reloaded until the header starts
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sh_out_q <= prts_pkg::STATUS_RESET;
      end else if (!cs_low || pre_hdr) begin
         sh_out_q <= status_rd;
      end else if (hdr_end) begin
         sh_out_q <= hdr_out;
      end else if (tbl_step) begin
         sh_out_q <= next_out;
      end else if (byte_end) begin
         sh_out_q <= status_wr;
      end else if (shift_so) begin
         sh_out_q <= {sh_out_q[6:0], 1'b0};
      end
   end

   // Serial output bit; ready level follows the supply until the first clock
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         so_q <= 1'b1;
      end else if (!cs_low || pre_hdr) begin
         so_q <= ~ready_i;
      end else if (shift_so) begin
         so_q <= sh_out_q[6];
      end else if (load_so) begin
         so_q <= sh_out_q[7];
      end
   end
endmodule
`default_nettype wire

// file: prts_host.sv
`timescale 1ns/100ps
`default_nettype none
module prts_host (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   // Link
   prts_link_if.host       link,
   // Command port
   input  wire logic [4:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o
);
   typedef enum logic [2:0] {
      PRTS_H_IDLE  = 3'b000,
      PRTS_H_WAIT  = 3'b001,
      PRTS_H_LOW   = 3'b010,
      PRTS_H_HIGH  = 3'b011,
      PRTS_H_DONE  = 3'b100
   } prts_host_st_t;

   prts_host_st_t st_q;
   logic [7:0] hdr_q;
   logic [3:0] len_q;
   logic [7:0] wbuf_q [8];
   logic [7:0] rbuf_q [8];
   logic [7:0] stat_q;
   logic [3:0] cnt_q;
   logic [2:0] bit_q;
   logic [3:0] div_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       sclk_q;
   logic       cs_n_q;
   logic [1:0] so_s_q;
   logic       busy_q;
   logic [7:0] rdata_q;

   wire        tick     = (div_q == 4'(prts_pkg::CLK_DIV_HALF - 1));
   wire        is_data  = addr_i[4:3] == prts_pkg::CMD_DATA_OFF[4:3];
   wire [7:0]  rx_next  = {rx_q[6:0], so_s_q[1]};
   wire        last_bit = (bit_q == 3'd7);
   wire [7:0]  rsel     = addr_i == prts_pkg::CMD_STAT_OFF ? stat_q :
                          addr_i == prts_pkg::CMD_HDR_OFF  ? hdr_q :
                          addr_i == prts_pkg::CMD_LEN_OFF  ? {4'h0, len_q} :
                          addr_i == prts_pkg::CMD_GO_OFF   ? {7'h00, busy_q} :
                          is_data ? rbuf_q[addr_i[2:0]] : 8'h00;

   assign link.sclk          = sclk_q;
   assign link.si            = tx_q[7];
   assign link.chip_select_n = cs_n_q;
   assign rdata_o            = rdata_q;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         so_s_q  <= 2'h3;
         rdata_q <= 8'h00;
      end else begin
         so_s_q  <= {so_s_q[0], link.so};
         rdata_q <= rd_i ? rsel : 8'h00;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q   <= PRTS_H_IDLE;
         hdr_q  <= 8'h00;
         len_q  <= 4'h0;
         stat_q <= 8'h00;
         cnt_q  <= 4'h0;
         bit_q  <= 3'h0;
         div_q  <= 4'h0;
         tx_q   <= 8'h00;
         rx_q   <= 8'h00;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         busy_q <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            wbuf_q[i] <= 8'h00;
            rbuf_q[i] <= 8'h00;
         end
      end else begin
         div_q <= tick ? 4'h0 : div_q + 4'h1;
         if (wr_i && !busy_q) begin
            if (addr_i == prts_pkg::CMD_HDR_OFF) hdr_q <= wdata_i;
            if (addr_i == prts_pkg::CMD_LEN_OFF) len_q <= wdata_i[3:0];
            if (is_data) wbuf_q[addr_i[2:0]] <= wdata_i;
         end
         case (st_q)
            PRTS_H_IDLE: begin
               if (wr_i && addr_i == prts_pkg::CMD_GO_OFF) begin
                  busy_q <= 1'b1;
                  cs_n_q <= 1'b0;
                  st_q   <= PRTS_H_WAIT;
               end
            end
            PRTS_H_WAIT: begin
               if (tick && !so_s_q[1]) begin
                  tx_q  <= hdr_q;
                  cnt_q <= 4'h0;
                  bit_q <= 3'h0;
                  st_q  <= PRTS_H_LOW;
               end
            end
            PRTS_H_LOW: begin
               if (tick) begin
                  sclk_q <= 1'b1;
                  rx_q   <= rx_next;
                  st_q   <= PRTS_H_HIGH;
               end
            end
            PRTS_H_HIGH: begin
               if (tick) begin
                  sclk_q <= 1'b0;
                  bit_q  <= bit_q + 3'd1;
                  tx_q   <= {tx_q[6:0], 1'b0};
                  st_q   <= PRTS_H_LOW;
                  if (last_bit) begin
                     if (cnt_q == 4'h0) stat_q <= rx_q;
                     else rbuf_q[3'(cnt_q - 4'h1)] <= rx_q;
                     tx_q  <= wbuf_q[cnt_q[2:0]];
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == len_q) st_q <= PRTS_H_DONE;
                  end
               end
            end
            PRTS_H_DONE: begin
               if (tick) begin
                  cs_n_q <= 1'b1;
                  busy_q <= 1'b0;
                  st_q   <= PRTS_H_IDLE;
               end
            end
            default: st_q <= PRTS_H_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: prts_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module prts_link_monitor (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   // Link
   input  wire logic sclk,
   input  wire logic si,
   input  wire logic so,
   input  wire logic chip_select_n
);
   logic       sclk_q;
   logic [6:0] rises_q;
   wire        rise    = sclk & ~sclk_q;
   wire  [6:0] rises_d = chip_select_n ? 7'h00 : rises_q + 7'(rise);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_q  <= 1'b0;
         rises_q <= 7'h00;
      end else begin
         sclk_q  <= sclk;
         rises_q <= rises_d;
      end
   end
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence high_phase;
      sclk [*8] ##1 !sclk;
   endsequence
   clk_in_frame_a: assert property ($rose(sclk) |-> !chip_select_n)
      else $error("sclk rose outside a frame");
   clk_high_len_a: assert property ($rose(sclk) |-> high_phase)
      else $error("sclk high phase length wrong");
   ready_first_a: assert property ($rose(sclk) && rises_q == 7'h00 |-> !so)
      else $error("first bit of status not low");
   so_hold_a: assert property (sclk && $past(sclk) |-> $stable(so))
      else $error("so moved while sclk high");
   si_hold_a: assert property (sclk && $past(sclk) |-> $stable(si))
      else $error("si moved while sclk high");
   whole_bytes_a: assert property ($rose(chip_select_n) |-> rises_q[2:0] == 3'h0)
      else $error("frame ended mid byte");
   frame_len_a: assert property ($rose(chip_select_n) |-> rises_q <= 7'd72)
      else $error("frame longer than nine bytes");
   idle_clk_a: assert property (chip_select_n |-> !sclk)
      else $error("sclk high while deselected");
endmodule
`default_nettype wire

// file: pa_table_and_status_byte_spi_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pa_table_and_status_byte_spi_tb_top;
   logic       ref_clk_i, rst_b_i, ready_i, sleep_enter_i, wr_i, rd_i, so_oe_o;
   logic [2:0] radio_state_i, power_level_selector_i;
   logic [6:0] rx_avail_i, tx_free_i;
   logic [4:0] addr_i;
   logic [7:0] wdata_i, rdata_o, pa_setting_o, v, keep;
   logic [7:0] tbl [8];
   int         miscompares, samples_checked;
   prts_link_if lnk ();
   prts_device i_prts_device (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link(lnk),
      .ready_i(ready_i), .radio_state_i(radio_state_i), .rx_avail_i(rx_avail_i),
      .tx_free_i(tx_free_i), .sleep_enter_i(sleep_enter_i),
      .power_level_selector_i(power_level_selector_i), .pa_setting_o(pa_setting_o),
      .so_oe_o(so_oe_o));
   prts_host i_prts_host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link(lnk),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   prts_link_monitor i_prts_link_monitor (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .sclk(lnk.sclk), .si(lnk.si), .so(lnk.so), .chip_select_n(lnk.chip_select_n));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic xfer(input logic [7:0] h, input int n);
      wr(prts_pkg::CMD_HDR_OFF, h);
      wr(prts_pkg::CMD_LEN_OFF, 8'(n));
      for (int i = 0; i < n; i++) wr(prts_pkg::CMD_DATA_OFF + 5'(i), tbl[i]);
      wr(prts_pkg::CMD_GO_OFF, 8'h01);
   endtask
   task automatic done();
      for (int k = 0; k < 5000; k++) begin
         rd(prts_pkg::CMD_GO_OFF);
         if (v[0] === 1'b0) return;
      end
      miscompares++;
      complete_run();
   endtask
   task automatic readback();
      xfer(8'hfe, 8);
      done();
      for (int i = 0; i < 8; i++) begin
         rd(prts_pkg::CMD_DATA_OFF + 5'(i));
         chk("entry", v, tbl[i]);
      end
   endtask
   initial begin
      {rst_b_i, ready_i, sleep_enter_i, wr_i, rd_i} = '0;
      radio_state_i = 3'h0;
      power_level_selector_i = 3'h0;
      rx_avail_i = 7'd20;
      tx_free_i = 7'd5;
      addr_i = 5'h00;
      wdata_i = 8'h00;
      miscompares = 0;
      samples_checked = 0;
      for (int i = 0; i < 8; i++) tbl[i] = 8'h13 * 8'(i + 1);
      repeat (6) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      // Burst write held off until ready
      xfer(8'h7e, 8);
      repeat (40) @(posedge ref_clk_i);
      rd(prts_pkg::CMD_GO_OFF);
      chk("busy", v, 8'h01);
      chk("so_oe", {7'h00, so_oe_o}, 8'h01);
      ready_i <= 1'b1;
      done();
      rd(prts_pkg::CMD_STAT_OFF);
      chk("status", v, 8'h0f);
      chk("so_oe", {7'h00, so_oe_o}, 8'h00);
      rd(prts_pkg::CMD_DATA_OFF);
      chk("wr status", v, 8'h05);
      readback();
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk_i);
         power_level_selector_i <= 3'(i);
         repeat (3) @(posedge ref_clk_i);
         #1 chk("pa", pa_setting_o, tbl[i]);
      end
      // Single write moves one entry only
      keep = tbl[1];
      tbl[0] = 8'haa;
      tbl[1] = 8'h55;
      xfer(8'h3e, 2);
      done();
      tbl[1] = keep;
      readback();
      // Sleep keeps entry zero
      @(posedge ref_clk_i);
      sleep_enter_i <= 1'b1;
      @(posedge ref_clk_i);
      sleep_enter_i <= 1'b0;
      for (int i = 1; i < 8; i++) tbl[i] = prts_pkg::TABLE_RESET;
      readback();
      for (int s = 0; s < 8; s++) begin
         @(posedge ref_clk_i);
         radio_state_i <= 3'(s);
         rx_avail_i <= 7'(s * 2);
         xfer(8'hbe, 2);
         done();
         rd(prts_pkg::CMD_STAT_OFF);
         chk("status", v, {1'b0, 3'(s), 4'(s * 2)});
         rd(prts_pkg::CMD_DATA_OFF);
         chk("single", v, tbl[0]);
      end
      rd(5'h06);
      chk("unmapped", v, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
